//--- shared/spu_cfg.svh
// Register offsets, field positions, reset values and counts of the serial port
`ifndef SPU_CFG_SVH
`define SPU_CFG_SVH

// Byte offsets on the register bus
`define SPU_ADDR_CTRL   8'h98
`define SPU_ADDR_BUF    8'h9C
`define SPU_ADDR_T1     8'hA0
`define SPU_ADDR_T2RLD  8'hA4
`define SPU_ADDR_STAT   8'hB0
`define SPU_ADDR_MASK   8'hB4
`define SPU_ADDR_T2CTL  8'hC8

// Serial control fields
`define SPU_CTL_SM0     7
`define SPU_CTL_SM1     6
`define SPU_CTL_SM2     5
`define SPU_CTL_REN     4
`define SPU_CTL_TB8     3
`define SPU_CTL_RB8     2
`define SPU_CTL_TI      1
`define SPU_CTL_RI      0

// Timer 2 control and timer 1 config fields
`define SPU_T2_RCLK     5
`define SPU_T2_TX_TIMER2_CLOCK_SEL     4
`define SPU_T1_SMOD     8

// Reset values
`define SPU_CTRL_RST    8'h00
`define SPU_T1_RST      9'h000
`define SPU_T2RLD_RST   16'h0000
`define SPU_T2CTL_RST   8'h00
`define SPU_MASK_RST    2'h0

// Timing counts
`define SPU_M0_DIV      12
`define SPU_T1_PRE_LAST 4'hB
`define SPU_OVS_LAST    4'hF
`define SPU_OVS_MID     4'h7
`define SPU_FRAME_LAST  4'h9
`define SPU_DATA_LAST   3'h7

`endif

//--- shared/spu_pkg.sv
// Types shared by the serial port modules
package spu_pkg;
  typedef enum logic [1:0] {
    SPU_MODE_SYNC,
    SPU_MODE_UART8,
    SPU_MODE_UART9F,
    SPU_MODE_UART9V
  } spu_mode_t;

  typedef enum {TX_IDLE, TX_M0, TX_M1} spu_tx_st_t;

  typedef enum {RX_IDLE, RX_M0, RX_START, RX_DATA, RX_STOP} spu_rx_st_t;
endpackage

//--- shared/spu_cnt_if.sv
// Reload counter hookup: reload value, step strobe and overflow tick
interface spu_cnt_if #(
  parameter int W = 8
);
  logic [W-1:0] reload;
  logic         step;
  logic         tick;

  modport ctl (output reload, output step, input tick);
  modport cnt (input reload, input step, output tick);
endinterface

//--- verilog/spu_rcnt.sv
// Up counter that reloads on overflow, used for both baud timers
module spu_rcnt (
  input wire logic hclk,
  input wire logic hresetn,
  spu_cnt_if.cnt   bus
);
  localparam int W = $bits(bus.reload);

  if (W < 2) begin
    $error("spu_rcnt needs a counter of at least 2 bits");
  end

  logic [W-1:0] cnt_q;
  wire          wrap;

  // Overflow seen only on a step, so the tick is one cycle wide
  assign wrap     = (cnt_q == {W{1'b1}});
  assign bus.tick = bus.step & wrap;

  // Count up, reload from software value on overflow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= {W{1'b0}};
    end else if (bus.step) begin
      cnt_q <= wrap ? bus.reload : cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

//--- verilog/spu_top.sv
// Serial port: AHB-Lite registers, synchronous shift mode and 8-bit UART
`include "spu_cfg.svh"

module spu_top
  import spu_pkg::*;
#(
  parameter int M0_DIV = `SPU_M0_DIV
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rxd_i,
  output logic             rxd_o,
  output logic             rxd_oe,
  output logic             txd_o,
  output logic             irq
);
  if ((M0_DIV < 4) || (M0_DIV > 16) || ((M0_DIV % 2) != 0)) begin
    $error("M0_DIV must be even and within 4..16");
  end

  localparam logic [3:0] PH_LAST = 4'(M0_DIV - 1);
  localparam logic [3:0] PH_HI   = 4'(M0_DIV / 2 - 1);
  localparam logic [3:0] PH_SMP  = 4'((M0_DIV * 3) / 4);

  // Registers
  logic [7:3]  ctl_q;
  logic        rb8_q;
  logic        ti_q;
  logic        ri_q;
  logic [8:0]  t1_cfg_q;
  logic [15:0] t2_rld_q;
  logic [7:0]  t2_ctl_q;
  logic [1:0]  mask_q;
  logic [7:0]  rx_buf_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        hresp_q;
  logic        irq_q;

  // Link state
  spu_tx_st_t  tx_st_q;
  spu_rx_st_t  rx_st_q;
  logic [9:0]  tx_sh_q;
  logic [3:0]  tx_bit_q;
  logic [3:0]  tx_os_q;
  logic        tx_line_q;
  logic        rxd_o_q;
  logic        rxd_oe_q;
  logic        txd_q;
  logic [7:0]  rx_sh_q;
  logic [2:0]  rx_bit_q;
  logic [3:0]  rx_os_q;
  logic        rxd_m_q;
  logic        rxd_s_q;
  logic        rxd_p_q;
  logic [3:0]  m0_ph_q;
  logic [2:0]  m0_bit_q;
  logic [3:0]  pre_q;
  logic        t1_half_q;
  logic        t2_half_q;

  spu_cnt_if #(.W(8))  t1_if ();
  spu_cnt_if #(.W(16)) t2_if ();

  // Mode decode
  spu_mode_t mode;
  wire       m_sync;
  wire       m_uart8;
  wire       ren;
  assign mode    = spu_mode_t'(ctl_q[`SPU_CTL_SM0:`SPU_CTL_SM1]);
  assign m_sync  = (mode == SPU_MODE_SYNC);
  assign m_uart8 = (mode == SPU_MODE_UART8);
  assign ren     = ctl_q[`SPU_CTL_REN];

  // Bus decode; upper address bits must be zero, else the access is ignored and hrdata keeps its value
  wire        a_hi_ok;
  wire        ahb_go;
  wire        ahb_rd;
  wire [7:0]  a_off;
  wire        wr_ctl;
  wire        wr_buf;
  wire        wr_t1;
  wire        wr_t2rld;
  wire        wr_t2ctl;
  wire        wr_stat;
  wire        wr_mask;
  wire [31:0] rd_mux;
  assign a_hi_ok  = (haddr[31:8] == 24'h00_0000);
  assign ahb_go   = hsel & hready & htrans[1] & a_hi_ok;
  assign ahb_rd   = ahb_go & ~hwrite;
  assign a_off    = haddr[7:0];
  assign wr_ctl   = wr_pend_q & (wr_addr_q == `SPU_ADDR_CTRL);
  assign wr_buf   = wr_pend_q & (wr_addr_q == `SPU_ADDR_BUF);
  assign wr_t1    = wr_pend_q & (wr_addr_q == `SPU_ADDR_T1);
  assign wr_t2rld = wr_pend_q & (wr_addr_q == `SPU_ADDR_T2RLD);
  assign wr_t2ctl = wr_pend_q & (wr_addr_q == `SPU_ADDR_T2CTL);
  assign wr_stat  = wr_pend_q & (wr_addr_q == `SPU_ADDR_STAT);
  assign wr_mask  = wr_pend_q & (wr_addr_q == `SPU_ADDR_MASK);

  // Read selection; unmapped offsets read as zero
  assign rd_mux =
    (a_off == `SPU_ADDR_CTRL)  ? {24'h00_0000, ctl_q, rb8_q, ti_q, ri_q} :
    (a_off == `SPU_ADDR_BUF)   ? {24'h00_0000, rx_buf_q} :
    (a_off == `SPU_ADDR_T1)    ? {23'h00_0000, t1_cfg_q} :
    (a_off == `SPU_ADDR_T2RLD) ? {16'h0000, t2_rld_q} :
    (a_off == `SPU_ADDR_T2CTL) ? {24'h00_0000, t2_ctl_q} :
    (a_off == `SPU_ADDR_STAT)  ? {30'h0000_0000, ti_q, ri_q} :
    (a_off == `SPU_ADDR_MASK)  ? {30'h0000_0000, mask_q} :
    32'h0000_0000;

  // Zero wait states: read data is latched in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      wr_pend_q <= ahb_go & hwrite;
      wr_addr_q <= a_off;
      if (ahb_rd) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // Baud sources: timer 1 behind a fixed prescaler, timer 2 every clock
  wire pre_wrap;
  wire t1_s16;
  wire t2_s16;
  wire tx_s16;
  wire rx_s16;
  assign pre_wrap     = (pre_q == `SPU_T1_PRE_LAST);
  assign t1_if.reload = t1_cfg_q[7:0];
  assign t1_if.step   = pre_wrap;
  assign t2_if.reload = t2_rld_q;
  assign t2_if.step   = 1'b1;
  // Sixteen ticks per bit: halve the overflow unless timer 1 doubles its rate
  assign t1_s16 = t1_if.tick & (t1_cfg_q[`SPU_T1_SMOD] | t1_half_q);
  assign t2_s16 = t2_if.tick & t2_half_q;
  assign tx_s16 = t2_ctl_q[`SPU_T2_TX_TIMER2_CLOCK_SEL] ? t2_s16 : t1_s16;
  assign rx_s16 = t2_ctl_q[`SPU_T2_RCLK] ? t2_s16 : t1_s16;

  spu_rcnt u_t1 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .bus     (t1_if)
  );

  spu_rcnt u_t2 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .bus     (t2_if)
  );

  // Prescaler and rate halving toggles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q     <= 4'h0;
      t1_half_q <= 1'b0;
      t2_half_q <= 1'b0;
    end else begin
      pre_q     <= pre_wrap ? 4'h0 : pre_q + 4'h1;
      t1_half_q <= t1_half_q ^ t1_if.tick;
      t2_half_q <= t2_half_q ^ t2_if.tick;
    end
  end

  // Receive pin synchroniser, third stage only for the edge detector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
      rxd_p_q <= 1'b1;
    end else begin
      rxd_m_q <= rxd_i;
      rxd_s_q <= rxd_m_q;
      rxd_p_q <= rxd_s_q;
    end
  end

  // Shift mode timing shared by send and receive
  wire m0_busy;
  wire m0_step;
  wire m0_end;
  wire m0_smp;
  wire sclk_hi;
  assign m0_busy = (tx_st_q == TX_M0) | (rx_st_q == RX_M0);
  assign m0_step = m0_busy & (m0_ph_q == PH_LAST);
  assign m0_end  = m0_step & (m0_bit_q == `SPU_DATA_LAST);
  assign m0_smp  = (rx_st_q == RX_M0) & (m0_ph_q == PH_SMP);
  assign sclk_hi = (m0_ph_q >= PH_HI) & (m0_ph_q != PH_LAST);

  // Phase runs only during a transfer so every bit starts on a fresh period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m0_ph_q  <= 4'h0;
      m0_bit_q <= 3'h0;
    end else if (!m0_busy) begin
      m0_ph_q  <= 4'h0;
      m0_bit_q <= 3'h0;
    end else begin
      m0_ph_q  <= m0_step ? 4'h0 : m0_ph_q + 4'h1;
      m0_bit_q <= m0_step ? m0_bit_q + 3'h1 : m0_bit_q;
    end
  end

  // Send start; a buffer write while busy is dropped
  wire tx_go_m0;
  wire tx_go_m1;
  wire tx_fin;
  assign tx_go_m0 = wr_buf & m_sync & (tx_st_q == TX_IDLE) & (rx_st_q == RX_IDLE);
  assign tx_go_m1 = wr_buf & m_uart8 & (tx_st_q == TX_IDLE);
  assign tx_fin   = ((tx_st_q == TX_M0) & m0_end) |
                    ((tx_st_q == TX_M1) & tx_s16 & (tx_os_q == `SPU_OVS_LAST) &
                     (tx_bit_q == `SPU_FRAME_LAST));

  // Transmitter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_q   <= TX_IDLE;
      tx_sh_q   <= 10'h000;
      tx_bit_q  <= 4'h0;
      tx_os_q   <= 4'h0;
      tx_line_q <= 1'b1;
      rxd_o_q   <= 1'b0;
      rxd_oe_q  <= 1'b0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_go_m0) begin
            tx_st_q  <= TX_M0;
            tx_sh_q  <= {2'b11, hwdata[7:0]};
            rxd_o_q  <= hwdata[0];
            rxd_oe_q <= 1'b1;
          end else if (tx_go_m1) begin
            tx_st_q   <= TX_M1;
            tx_sh_q   <= {1'b1, hwdata[7:0], 1'b0};
            tx_line_q <= 1'b0;
            tx_bit_q  <= 4'h0;
            tx_os_q   <= 4'h0;
          end
        end
        TX_M0: begin
          if (m0_step) begin
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            rxd_o_q <= tx_sh_q[1];
            if (m0_end) begin
              tx_st_q  <= TX_IDLE;
              rxd_o_q  <= 1'b0;
              rxd_oe_q <= 1'b0;
            end
          end
        end
        TX_M1: begin
          if (tx_s16) begin
            tx_os_q <= tx_os_q + 4'h1;
            if (tx_os_q == `SPU_OVS_LAST) begin
              tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
              tx_line_q <= tx_sh_q[1];
              tx_bit_q  <= tx_bit_q + 4'h1;
              if (tx_bit_q == `SPU_FRAME_LAST) begin
                tx_st_q   <= TX_IDLE;
                tx_line_q <= 1'b1;
              end
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // Receive start and completion
  wire rx_fall;
  wire rx_go_m0;
  wire rx_accept;
  wire rx_fin_m1;
  wire rx_fin;
  assign rx_fall   = rxd_p_q & ~rxd_s_q;
  assign rx_go_m0  = (rx_st_q == RX_IDLE) & m_sync & ren & ~ri_q &
                     (tx_st_q == TX_IDLE) & ~wr_buf;
  // A full flag or a bad stop under the option bit throws the frame away
  assign rx_accept = ~ri_q & (~ctl_q[`SPU_CTL_SM2] | rxd_s_q);
  assign rx_fin_m1 = (rx_st_q == RX_STOP) & rx_s16 & (rx_os_q == `SPU_OVS_LAST) &
                     rx_accept;
  assign rx_fin    = rx_fin_m1 | ((rx_st_q == RX_M0) & m0_end);

  // Transmit pin: shift clock in shift mode, serial line otherwise;
  // dropped on the start edge so the first bit's low phase is full length
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_q <= 1'b1;
    end else if (tx_go_m0 | rx_go_m0) begin
      txd_q <= 1'b0;
    end else begin
      txd_q <= (m0_busy & ~m0_end) ? sclk_hi : tx_line_q;
    end
  end

  // Receiver
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_q  <= RX_IDLE;
      rx_sh_q  <= 8'h00;
      rx_bit_q <= 3'h0;
      rx_os_q  <= 4'h0;
    end else begin
      case (rx_st_q)
        RX_IDLE: begin
          rx_os_q <= 4'h0;
          if (rx_go_m0) begin
            rx_st_q <= RX_M0;
          end else if (m_uart8 & ren & rx_fall) begin
            rx_st_q <= RX_START;
          end
        end
        RX_M0: begin
          if (m0_smp) begin
            rx_sh_q <= {rxd_s_q, rx_sh_q[7:1]};
          end
          if (m0_end) begin
            rx_st_q <= RX_IDLE;
          end
        end
        RX_START: begin
          if (rx_s16) begin
            rx_os_q <= rx_os_q + 4'h1;
            // Mid start bit: restart the bit clock here, or reject a glitch
            if (rx_os_q == `SPU_OVS_MID) begin
              rx_os_q  <= 4'h0;
              rx_bit_q <= 3'h0;
              rx_st_q  <= rxd_s_q ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (rx_s16) begin
            rx_os_q <= rx_os_q + 4'h1;
            if (rx_os_q == `SPU_OVS_LAST) begin
              rx_sh_q  <= {rxd_s_q, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == `SPU_DATA_LAST) begin
                rx_st_q <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (rx_s16) begin
            rx_os_q <= rx_os_q + 4'h1;
            if (rx_os_q == `SPU_OVS_LAST) begin
              rx_st_q <= RX_IDLE;
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Flag next values; a hardware set beats a software clear
  wire ti_d;
  wire ri_d;
  wire rb8_d;
  assign ti_d  = tx_fin | (wr_ctl ? hwdata[`SPU_CTL_TI] :
                 (ti_q & ~(wr_stat & hwdata[1])));
  assign ri_d  = rx_fin | (wr_ctl ? hwdata[`SPU_CTL_RI] :
                 (ri_q & ~(wr_stat & hwdata[0])));
  assign rb8_d = rx_fin_m1 ? rxd_s_q :
                 (wr_ctl ? hwdata[`SPU_CTL_RB8] : rb8_q);

  // Control, flags and receive buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_q    <= 5'(`SPU_CTRL_RST >> 3);
      rb8_q    <= 1'b0;
      ti_q     <= 1'b0;
      ri_q     <= 1'b0;
      rx_buf_q <= 8'h00;
    end else begin
      if (wr_ctl) begin
        ctl_q <= hwdata[7:3];
      end
      rb8_q <= rb8_d;
      ti_q  <= ti_d;
      ri_q  <= ri_d;
      if (rx_fin) begin
        rx_buf_q <= rx_sh_q;
      end
    end
  end

  // Baud configuration and interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t1_cfg_q <= `SPU_T1_RST;
      t2_rld_q <= `SPU_T2RLD_RST;
      t2_ctl_q <= `SPU_T2CTL_RST;
      mask_q   <= `SPU_MASK_RST;
    end else begin
      if (wr_t1) t1_cfg_q <= hwdata[8:0];
      if (wr_t2rld) t2_rld_q <= hwdata[15:0];
      if (wr_t2ctl) t2_ctl_q <= hwdata[7:0];
      if (wr_mask) mask_q <= hwdata[1:0];
    end
  end

  // Level interrupt follows the flags whoever changed them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (ti_q & mask_q[1]) | (ri_q & mask_q[0]);
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign rxd_o     = rxd_o_q;
  assign rxd_oe    = rxd_oe_q;
  assign txd_o     = txd_q;
  assign irq       = irq_q;
endmodule

//--- verification/spu_top_assertions.sv
// Port-level checker for the serial port, bound into spu_top
module spu_top_assertions #(
  parameter int M0_DIV = 12
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rxd_o,
  input wire logic        rxd_oe,
  input wire logic        txd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] low_q;
  logic [3:0] fall_q;
  logic       txd_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Low run of the shift clock and count of clock falls per transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_q  <= 5'h00;
      fall_q <= 4'h0;
      txd_q  <= 1'b1;
    end else begin
      txd_q  <= txd_o;
      low_q  <= txd_o ? 5'h00 : low_q + 5'h01;
      fall_q <= !rxd_oe ? 4'h0 : fall_q + {3'h0, txd_q & !txd_o};
    end
  end

  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_read_change: assert property ($changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
    else $error("hrdata moved without a read");
  a_clk_starts: assert property ($rose(rxd_oe) |-> ##[1:8] !txd_o)
    else $error("no shift clock after drive start");
  a_low_half: assert property ($rose(txd_o) && rxd_oe |-> low_q == M0_DIV / 2)
    else $error("shift clock low phase length wrong");
  a_bit_count: assert property ($fell(rxd_oe) |-> fall_q == 4'h8)
    else $error("sync transfer bit count wrong");
  a_data_edge: assert property (rxd_oe && $past(rxd_oe) && $changed(rxd_o) |-> ##[0:1] !txd_o)
    else $error("sync data moved while clock high");
  a_end_idle: assert property ($fell(rxd_oe) |-> txd_o)
    else $error("shift clock not idle high at end");
  a_rx_released: assert property (!rxd_oe |-> !rxd_o)
    else $error("receive pin data while released");
endmodule

bind spu_top spu_top_assertions #(.M0_DIV(M0_DIV)) i_spu_top_assertions (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd_o(txd_o)
);

//--- verification/spu_peer.sv
// Serial peer: drives the receive pin with async frames or sync-mode bits
module spu_peer (
  input  wire logic hclk,
  input  wire logic txd_i,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line idles high, as a pull-up would leave it
  initial rxd = 1'b1;

  // Async frame: start 0, data LSB first, stop 1, each bit per cycles
  task automatic send_uart(input logic [7:0] b, input int per);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge hclk);
      rxd <= f[i];
      repeat (per - 1) @(posedge hclk);
    end
  endtask

  // Sync mode: next bit offered on each falling shift clock
  task automatic send_sync(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd_i);
      rxd <= b[i];
    end
    @(posedge txd_i);
    repeat (4) @(posedge hclk);
    rxd <= 1'b1;
  endtask
endmodule

//--- verification/tb.sv
// Self-checking bench for the serial port
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } spu_row_t;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0000_0000;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rxd_i;
  logic        rxd_o;
  logic        rxd_oe;
  logic        txd_o;
  logic        irq;
  logic [31:0] r;
  logic [9:0]  fr;
  logic [7:0]  sh = 8'h00;
  logic [31:0] nb = 32'h0000_0000;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  // Reset values first, then write and read back; 0xE0 is unmapped
  spu_row_t rows [9] = '{
    '{1'b0, 8'h98, 32'h0, 32'h0}, '{1'b0, 8'hC8, 32'h0, 32'h0},
    '{1'b0, 8'hB4, 32'h0, 32'h0}, '{1'b0, 8'hA0, 32'h0, 32'h0},
    '{1'b1, 8'hA0, 32'h0000_01F5, 32'h0000_01F5},
    '{1'b1, 8'hE0, 32'h0000_0055, 32'h0},
    '{1'b1, 8'hA4, 32'h0000_FFFE, 32'h0000_FFFE},
    '{1'b1, 8'hC8, 32'h0000_0030, 32'h0000_0030},
    '{1'b1, 8'hB4, 32'h0000_0003, 32'h0000_0003}};

  spu_top #(.M0_DIV(12)) i_spu_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd_i(rxd_i),
    .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd_o(txd_o), .irq(irq));
  spu_peer i_spu_peer (.hclk(hclk), .txd_i(txd_o), .rxd(rxd_i));

  always #20 hclk = ~hclk;

  // Sync-mode data captured on each rising shift clock
  always @(posedge txd_o) begin
    if (rxd_oe === 1'b1) begin
      sh = {rxd_o, sh[7:1]};
      nb = nb + 1;
    end
  end

  // Hang guard well beyond the expected run
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 75000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  // One single AHB transfer; waits on hready in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd_cmp(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    cmp(n, e, q);
  endtask

  // Irq is registered one cycle behind the flags
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge hclk);
    cmp("irq", {31'h0, e}, {31'h0, irq});
  endtask

  task automatic wait_irq();
    for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge hclk);
    cmp("irq_wait", 32'h1, {31'h0, irq});
  endtask

  // Samples the transmit pin mid-bit; settled values read at falling clock
  task automatic uart_grab(input int per, output logic [9:0] f);
    @(negedge txd_o);
    repeat (per / 2) @(negedge hclk);
    for (int i = 0; i < 10; i++) begin
      f[i] = txd_o;
      repeat (per) @(negedge hclk);
    end
  endtask

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    cmp("irq_rst", 32'h0, {31'h0, irq});
    cmp("txd_rst", 32'h1, {31'h0, txd_o});
    cmp("resp_rst", 32'h0, {31'h0, hresp});
    for (int i = 0; i < 9; i++) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd_cmp("reg", rows[i].a, rows[i].e);
    end
    // Sync transmit of one byte
    wr(8'h98, 32'h0);
    wr(8'h9C, 32'h0000_00A5);
    wait_irq();
    cmp("sync_tx", 32'h0000_00A5, {24'h0, sh});
    cmp("sync_bits", 32'h8, nb);
    rd_cmp("ctrl_ti", 8'h98, 32'h0000_0002);
    wr(8'hB0, 32'h0000_0002);
    chk_irq(1'b0);
    // Sync receive starts on enable with the receive flag clear
    fork
      i_spu_peer.send_sync(8'h3C);
    join_none
    wr(8'h98, 32'h0000_0010);
    wait_irq();
    rd_cmp("sync_rx", 8'h9C, 32'h0000_003C);
    wr(8'h98, 32'h0000_0040);
    chk_irq(1'b0);
    wr(8'h98, 32'h0000_0041);
    chk_irq(1'b1);
    wr(8'h98, 32'h0000_0050);
    chk_irq(1'b0);
    // UART transmit on timer 2, reload giving 64 cycles a bit
    // Timer 2 climbs from zero after reset, so its first overflow is far off
    while (cyc < 65600) @(posedge hclk);
    fork
      uart_grab(64, fr);
      wr(8'h9C, 32'h0000_0096);
    join
    cmp("uart_tx", {22'h0, 1'b1, 8'h96, 1'b0}, {22'h0, fr});
    cmp("oe_uart", 32'h0, {31'h0, rxd_oe});
    wait_irq();
    wr(8'hB0, 32'h0000_0002);
    // UART receive at an arbitrary phase against the sample ticks
    repeat (37) @(posedge hclk);
    i_spu_peer.send_uart(8'h5A, 64);
    wait_irq();
    rd_cmp("uart_rx", 8'h9C, 32'h0000_005A);
    rd_cmp("ctrl_rx", 8'h98, 32'h0000_0055);
    // Receive flag still set: the next frame is thrown away
    i_spu_peer.send_uart(8'hA3, 64);
    rd_cmp("rx_full", 8'h9C, 32'h0000_005A);
    wr(8'h98, 32'h0000_0050);
    chk_irq(1'b0);
    // Timer 1 at double rate, reload 0xFF: 192 cycles a bit
    wr(8'hC8, 32'h0);
    wr(8'hA0, 32'h0000_01FF);
    // Let the old reload run out before the frame starts
    repeat (200) @(posedge hclk);
    fork
      uart_grab(192, fr);
      wr(8'h9C, 32'h0000_000F);
    join
    cmp("uart_t1", {22'h0, 1'b1, 8'h0F, 1'b0}, {22'h0, fr});
    wait_irq();
    end_sim();
  end
endmodule
